// File: rtl/pic_core.sv
// Purpose: prioritised interrupt controller core, 128 sources, normal and fast requests
// Assumes: sources and write port synchronous to clk; supervisor flag comes from the bus master
// Notes:   all outputs registered, one cycle behind their cause
//
// Notes on behaviour
// RQ1: up to 128 interrupt source inputs are gathered and arbitrated.
// RQ2: per-source enable, set by bitmap word or by enable/disable number.
// RQ3: enabled asserted source raises normal or fast request per its type bit.
// RQ4: configuration writes only take effect in supervisor mode.
// RQ5: fast beats normal; fast by higher source number; normal by highest level, ties to higher number.
// RQ6: sixteen normal levels per source, zero lowest.
// RQ7: levels programmed through eight priority level words.
// RQ8: normal mask register gives software priority masking.
// RQ9: normal requests at or below mask level are blocked; fast unaffected.
// RQ10: request output held while any qualifying source stays asserted.

`timescale 1ns/10ps

module pic_core (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 ce,
    input  wire logic [pic_pkg::NUM_SRC-1:0]          src_i,
    input  wire logic                                 cfg_we,
    input  wire logic                                 cfg_sup,
    input  wire pic_pkg::pic_kind_e                   cfg_kind,
    input  wire logic [pic_pkg::IDX_W-1:0]            cfg_idx,
    input  wire logic [pic_pkg::DATA_W-1:0]           cfg_wdata,
    output logic                                      irq_norm_q,
    output logic                                      irq_fast_q,
    output logic                                      win_valid_q,
    output logic                                      win_fast_q,
    output pic_pkg::pic_src_t                         win_src_q,
    output logic                                      cfg_err_q,
    output logic [pic_pkg::NUM_SRC-1:0]               en_q,
    output logic [pic_pkg::NUM_SRC-1:0]               typ_q,
    output logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] lvl_q,
    output logic [pic_pkg::MASK_W-1:0]                mask_q
);
    import pic_pkg::*;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [NUM_SRC-1:0] merge(input logic [NUM_SRC-1:0] old_v,
                                                 input logic [NUM_SRC-1:0] sel,
                                                 input logic [NUM_SRC-1:0] data);
        merge = (old_v & ~sel) | (data & sel);
    endfunction

    // top mask bit set means masking off
    function automatic logic lvl_passes(input pic_lvl_t l, input logic [MASK_W-1:0] m);
        lvl_passes = m[MASK_OFF_BIT] || ({1'b0, l} > m);
    endfunction

    // -------------------------------------------------------------------
    // write decode
    // -------------------------------------------------------------------
    logic [NUM_SRC-1:0]       en_d;
    logic [NUM_SRC-1:0]       typ_d;
    logic [NUM_SRC*LVL_W-1:0] lvl_d;
    logic [MASK_W-1:0]        mask_d;

    // RQ4: supervisor gate
    wire                       wr_ok     = ce && cfg_we && cfg_sup;
    wire                       wr_bad    = ce && cfg_we && !cfg_sup;
    wire [NUM_SRC-1:0]         word_sel  = {{DATA_W{cfg_idx[0]}}, {DATA_W{~cfg_idx[0]}}};
    wire [NUM_SRC-1:0]         word_dat  = {cfg_wdata, cfg_wdata};
    wire [NUM_SRC-1:0]         num_bit   = NUM_SRC'(1) << cfg_wdata[SRC_W-1:0];
    wire [NUM_SRC*LVL_W-1:0]   lvl_sel   = {{(NUM_SRC*LVL_W-DATA_W){1'b0}}, {DATA_W{1'b1}}}
                                           << {cfg_idx, WORD_SHIFT'(0)};
    wire [NUM_SRC*LVL_W-1:0]   lvl_dat   = {NUM_PRIO_REG{cfg_wdata}};

    wire is_en_word  = wr_ok && (cfg_kind == PIC_WR_EN_WORD);
    wire is_en_num   = wr_ok && (cfg_kind == PIC_WR_EN_NUM);
    wire is_dis_num  = wr_ok && (cfg_kind == PIC_WR_DIS_NUM);
    wire is_type     = wr_ok && (cfg_kind == PIC_WR_TYPE_WORD);
    wire is_prio     = wr_ok && (cfg_kind == PIC_WR_PRIO_WORD);
    wire is_mask     = wr_ok && (cfg_kind == PIC_WR_MASK);

    // RQ2: bitmap or number access
    always_comb begin
        case (1'b1)
            is_en_word: en_d = merge(en_q, word_sel, word_dat);
            is_en_num:  en_d = en_q | num_bit;
            is_dis_num: en_d = en_q & ~num_bit;
            default:    en_d = en_q;
        endcase
    end

    assign typ_d  = is_type ? merge(typ_q, word_sel, word_dat) : typ_q;
    // RQ7: eight level words
    assign lvl_d  = is_prio ? ((lvl_q & ~lvl_sel) | (lvl_dat & lvl_sel)) : lvl_q;
    // RQ8: mask write
    assign mask_d = is_mask ? cfg_wdata[MASK_W-1:0] : mask_q;

    // -------------------------------------------------------------------
    // request qualification
    // -------------------------------------------------------------------
    // RQ1: all sources gathered
    // RQ3: type bit steers request
    wire [NUM_SRC-1:0] active   = src_i & en_q;
    wire [NUM_SRC-1:0] fast_req = active & typ_q;
    wire [NUM_SRC-1:0] norm_raw = active & ~typ_q;
    logic [NUM_SRC-1:0] norm_pass;

    // RQ9: level mask on normal only
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            norm_pass[i] = norm_raw[i] && lvl_passes(lvl_q[i*LVL_W +: LVL_W], mask_q);
        end
    end

    logic     arb_valid;
    logic     arb_fast;
    pic_src_t arb_src;

    pic_arbiter u_arb (
        .fast_req  (fast_req),
        .norm_req  (norm_pass),
        .lvl       (lvl_q),
        .win_valid (arb_valid),
        .win_fast  (arb_fast),
        .win_src   (arb_src)
    );

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q   <= EN_RST;
            typ_q  <= TYP_RST;
            lvl_q  <= LVL_RST;
            mask_q <= MASK_RST;
        end else if (ce) begin
            en_q   <= en_d;
            typ_q  <= typ_d;
            lvl_q  <= lvl_d;
            mask_q <= mask_d;
        end
    end

    // RQ10: level outputs follow pending set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_norm_q  <= 1'b0;
            irq_fast_q  <= 1'b0;
            win_valid_q <= 1'b0;
            win_fast_q  <= 1'b0;
            win_src_q   <= '0;
            cfg_err_q   <= 1'b0;
        end else if (ce) begin
            irq_norm_q  <= |norm_pass;
            irq_fast_q  <= |fast_req;
            win_valid_q <= arb_valid;
            win_fast_q  <= arb_fast;
            win_src_q   <= arb_src;
            cfg_err_q   <= wr_bad;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fast_raise: assert property (ce && (|fast_req) |=> irq_fast_q) // RQ3
        else $error("fast request not raised");
    a_fast_hold_drop: assert property (ce && !(|fast_req) |=> !irq_fast_q) // RQ10
        else $error("fast request held without source");
    a_norm_mask_block: assert property (ce && !(|norm_pass) |=> !irq_norm_q) // RQ9
        else $error("masked normal request reached output");
    a_user_write_ignored: assert property (wr_bad |=> $stable(en_q) && $stable(typ_q) // RQ4
                                           && $stable(lvl_q) && $stable(mask_q) && cfg_err_q)
        else $error("user mode write changed configuration");
    a_enable_by_num: assert property (is_en_num |=> en_q[$past(cfg_wdata[SRC_W-1:0])]) // RQ2
        else $error("enable number did not set enable");
    a_disable_by_num: assert property (is_dis_num |=> !en_q[$past(cfg_wdata[SRC_W-1:0])]) // RQ2
        else $error("disable number did not clear enable");
    a_fast_first: assert property (ce && (|fast_req) |=> win_valid_q && win_fast_q) // RQ5
        else $error("normal source beat a fast one");
    a_prio_word_write: assert property (is_prio |=> lvl_q[$past(cfg_idx)*DATA_W +: DATA_W] // RQ7
                                        == $past(cfg_wdata))
        else $error("priority word not stored");
    a_mask_stored: assert property (is_mask |=> mask_q == $past(cfg_wdata[MASK_W-1:0])) // RQ8
        else $error("mask write not stored");
    a_winner_level: assert property (ce && arb_valid && !arb_fast |=> // RQ9
                                     win_valid_q && lvl_passes(lvl_q[win_src_q*LVL_W +: LVL_W], mask_q)
                                     || !$stable(lvl_q) || !$stable(mask_q))
        else $error("winner below mask level");
    a_pending_winner: assert property (ce && |(fast_req | norm_pass) |=> win_valid_q) // RQ1
        else $error("pending source without winner");

    // RQ3: normal raised, mask off
    a_norm_raise: assert property (ce && (|norm_raw) && mask_q[MASK_OFF_BIT] |=> irq_norm_q) // RQ3
        else $error("normal request not raised");
    // RQ9: winner above threshold
    a_mask_threshold: assert property (ce && arb_valid && !arb_fast && !mask_q[MASK_OFF_BIT] // RQ9
                                       |-> lvl_q[arb_src*LVL_W +: LVL_W] > mask_q[LVL_W-1:0])
        else $error("normal winner at or below mask level");
    // RQ5: highest fast number
    a_fast_top_num: assert property (ce && arb_valid && arb_fast |-> (fast_req >> arb_src) == NUM_SRC'(1)) // RQ5
        else $error("fast winner not the highest source");
    // RQ5: normal only without fast
    a_norm_no_fast: assert property (ce && arb_valid && !arb_fast |-> norm_pass[arb_src] && !(|fast_req)) // RQ5
        else $error("normal winner while fast pending");
    // RQ2: enable word lands
    a_en_word_low: assert property (is_en_word && !cfg_idx[0] |=> en_q[DATA_W-1:0] == $past(cfg_wdata)) // RQ2
        else $error("enable word not stored");
    // RQ3: type word lands
    a_type_word_low: assert property (is_type && !cfg_idx[0] |=> typ_q[DATA_W-1:0] == $past(cfg_wdata)) // RQ3
        else $error("type word not stored");
    // RQ4: no write without ce
    a_cfg_frozen: assert property (!ce |=> $stable(en_q) && $stable(typ_q) && $stable(lvl_q) // RQ4
                                   && $stable(mask_q))
        else $error("configuration changed while clock enable low");
    // RQ4: error only when refused
    a_err_only_bad: assert property (ce && !wr_bad |=> !cfg_err_q) // RQ4
        else $error("error pulse without refused write");

endmodule // pic_core

// File: include/pic_pkg.sv
// Purpose: shared constants and types of the prioritised interrupt controller
// Assumes: 128 sources, 4-bit normal levels, 64-bit configuration words
// Notes:   mask encoding and write kinds are used by the core; sizes and types by core and arbiter

package pic_pkg;

    // -------------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------------
    localparam int NUM_SRC      = 128;
    localparam int SRC_W        = 7;
    localparam int LVL_W        = 4;
    localparam int NUM_PRIO_REG = 8;
    localparam int DATA_W       = 64;
    localparam int IDX_W        = 3;
    localparam int MASK_W       = 5;
    localparam int MASK_OFF_BIT = 4;
    localparam int WORD_SHIFT   = 6;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [NUM_SRC-1:0]       EN_RST   = 128'h0;
    localparam logic [NUM_SRC-1:0]       TYP_RST  = 128'h0;
    localparam logic [NUM_SRC*LVL_W-1:0] LVL_RST  = 512'h0;
    localparam logic [MASK_W-1:0]        MASK_RST = 5'h10;

    typedef logic [SRC_W-1:0] pic_src_t;
    typedef logic [LVL_W-1:0] pic_lvl_t;

    // kind of configuration write carried by the write port
    typedef enum logic [2:0] {
        PIC_WR_EN_WORD,
        PIC_WR_EN_NUM,
        PIC_WR_DIS_NUM,
        PIC_WR_TYPE_WORD,
        PIC_WR_PRIO_WORD,
        PIC_WR_MASK
    } pic_kind_e;

endpackage

// File: rtl/pic_arbiter.sv
// Purpose: picks the winning pending source of the controller
// Assumes: request vectors already gated by enable and type, the normal one also by mask
// Notes:   purely combinational; the core registers its result

`timescale 1ns/10ps

module pic_arbiter (
    input  wire logic [pic_pkg::NUM_SRC-1:0]              fast_req,
    input  wire logic [pic_pkg::NUM_SRC-1:0]              norm_req,
    input  wire logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] lvl,
    output logic                                          win_valid,
    output logic                                          win_fast,
    output pic_pkg::pic_src_t                             win_src
);
    import pic_pkg::*;

    // not worse than the current best; scanning upward makes ties go high
    function automatic logic not_worse(input logic f, input pic_lvl_t l,
                                       input logic bf, input pic_lvl_t bl);
        not_worse = (f && !bf) || ((f == bf) && (f || (l >= bl)));
    endfunction

    pic_lvl_t best_l;

    // RQ5: fast first by number; normal by level, then number
    // RQ6: zero ranks lowest
    always_comb begin
        win_valid = 1'b0;
        win_fast  = 1'b0;
        win_src   = '0;
        best_l    = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (fast_req[i] || norm_req[i]) begin
                if (!win_valid || not_worse(fast_req[i], lvl[i*LVL_W +: LVL_W], win_fast, best_l)) begin
                    win_valid = 1'b1;
                    win_fast  = fast_req[i];
                    win_src   = pic_src_t'(i);
                    best_l    = lvl[i*LVL_W +: LVL_W];
                end
            end
        end
    end

endmodule // pic_arbiter

// File: tb/pic_cpu_model.sv
// Purpose: processor core side of the controller, takes the two request lines
// Assumes: requests are registered levels from the controller
// Notes:   reports what it would service on each edge as one vector

`timescale 1ns/10ps

module pic_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        irq_norm,
    input  wire logic        irq_fast,
    input  wire logic        win_valid,
    input  wire logic        win_fast,
    input  wire logic [6:0]  win_src,
    output logic      [10:0] svc_vec
);
    // -------------------------------------------------------------------
    // sampling
    // -------------------------------------------------------------------
    // level requests only, so the core samples once per edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_vec <= 11'h000;
        end else begin
            svc_vec <= {irq_norm, irq_fast, win_valid, win_fast, win_src};
        end
    end
endmodule // pic_cpu_model

// File: tb/tb_pic_core.sv
// Purpose: self-checking bench of the interrupt controller core
// Assumes: writes taken with ce and supervisor flag high
// Notes:   expected request vectors queue up and a monitor compares them

`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, ex, got); end end

module tb_pic_core;
    import pic_pkg::*;
    logic                         clk = 1'b0;
    logic                         rst_n = 1'b0;
    logic                         ce = 1'b0;
    logic                         look = 1'b0;
    logic                         cfg_we = 1'b0;
    logic                         cfg_sup = 1'b0;
    pic_kind_e                    cfg_kind = PIC_WR_EN_WORD;
    logic [IDX_W-1:0]             cfg_idx = 3'h0;
    logic [DATA_W-1:0]            cfg_wdata = 64'h0;
    logic [NUM_SRC-1:0]           src_i = 128'h0;
    logic                         irq_norm_q, irq_fast_q, win_valid_q, win_fast_q, cfg_err_q;
    pic_src_t                     win_src_q;
    logic [NUM_SRC-1:0]           en_q, typ_q;
    logic [NUM_SRC*LVL_W-1:0]     lvl_q;
    logic [MASK_W-1:0]            mask_q;
    logic [10:0]                  svc_vec, e_now;
    logic [10:0]                  exp_q[$];
    logic [6:0]                   n;
    int                           n_fail = 0;
    int                           n_tests = 0;
    int                           seed;

    always #5 clk = ~clk;

    pic_core u_pic_core (.clk(clk), .rst_n(rst_n), .ce(ce), .src_i(src_i), .cfg_we(cfg_we),
        .cfg_sup(cfg_sup), .cfg_kind(cfg_kind), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
        .irq_norm_q(irq_norm_q), .irq_fast_q(irq_fast_q), .win_valid_q(win_valid_q),
        .win_fast_q(win_fast_q), .win_src_q(win_src_q), .cfg_err_q(cfg_err_q), .en_q(en_q),
        .typ_q(typ_q), .lvl_q(lvl_q), .mask_q(mask_q));

    pic_cpu_model u_pic_cpu_model (.clk(clk), .rst_n(rst_n), .irq_norm(irq_norm_q),
        .irq_fast(irq_fast_q), .win_valid(win_valid_q), .win_fast(win_fast_q),
        .win_src(win_src_q), .svc_vec(svc_vec));

    // -------------------------------------------------------------------
    // drivers and checks
    // -------------------------------------------------------------------
    task automatic wr(input pic_kind_e k, input logic [2:0] i, input logic [63:0] d, input logic sup);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_kind <= k;
        cfg_idx <= i;
        cfg_wdata <= d;
        cfg_sup <= sup;
        @(posedge clk);
        cfg_we <= 1'b0;
    endtask

    task automatic expect_out(input logic [10:0] e);
        exp_q.push_back(e);
        repeat (3) @(posedge clk);
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask

    always @(negedge clk) begin
        if (look) begin
            e_now = exp_q.pop_front();
            `CHK("svc_vec", e_now, svc_vec)
        end
    end

    task automatic results;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_fail++;
        results();
    end

    initial begin
        seed = 32'hfaf52c1a;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        ce <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("mask_q", 5'h10, mask_q)
        `CHK("en_q", 128'h0, en_q)
        // level words, sources 2 4 6
        wr(PIC_WR_PRIO_WORD, 3'h0, 64'h0000_0000_090c_0900, 1'b1);
        // readback settles after the write edge
        #1;
        `CHK("lvl_q", 32'h090c_0900, lvl_q[31:0])
        wr(PIC_WR_EN_WORD, 3'h0, 64'h44, 1'b1);
        src_i <= 128'h5c;
        // nibble order: normal, fast, valid, winner fast
        expect_out({4'ha, 7'h06});
        wr(PIC_WR_EN_NUM, 3'h0, 64'h4, 1'b1);
        expect_out({4'ha, 7'h04});
        wr(PIC_WR_MASK, 3'h0, 64'h09, 1'b1);
        expect_out({4'ha, 7'h04});
        wr(PIC_WR_MASK, 3'h0, 64'h0c, 1'b1);
        expect_out({4'h0, 7'h00});
        wr(PIC_WR_TYPE_WORD, 3'h0, 64'h8, 1'b1);
        #1;
        `CHK("typ_q", 128'h8, typ_q)
        wr(PIC_WR_EN_NUM, 3'h0, 64'h3, 1'b1);
        expect_out({4'h7, 7'h03});
        wr(PIC_WR_MASK, 3'h0, 64'h10, 1'b1);
        expect_out({4'hf, 7'h03});
        wr(PIC_WR_MASK, 3'h0, 64'h05, 1'b0);
        #1;
        `CHK("cfg_err_q", 1'b1, cfg_err_q)
        `CHK("mask_q", 5'h10, mask_q)
        // clock enable low drops a legal write
        ce <= 1'b0;
        wr(PIC_WR_MASK, 3'h0, 64'h05, 1'b1);
        #1;
        `CHK("mask_q", 5'h10, mask_q)
        ce <= 1'b1;
        wr(PIC_WR_EN_WORD, 3'h0, 64'h0, 1'b1);
        wr(PIC_WR_TYPE_WORD, 3'h0, 64'h0, 1'b1);
        expect_out({4'h0, 7'h00});
        for (int k = 0; k < 9; k++) begin
            n = (k == 0) ? 7'h7f : 7'($random(seed));
            wr(PIC_WR_EN_NUM, 3'h0, {57'h0, n}, 1'b1);
            src_i <= 128'h1 << n;
            #1;
            `CHK("en_q", 1'b1, en_q[n])
            expect_out({4'ha, n});
            wr(PIC_WR_DIS_NUM, 3'h0, {57'h0, n}, 1'b1);
            expect_out({4'h0, 7'h00});
        end
        results();
    end
endmodule // tb_pic_core
